// ===== shared/trig_pkg.sv
package trig_pkg;

  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int SAMPLE_W = 16;
  localparam int AW = 10;
  localparam int DEPTH = 1024;
  localparam int CNT_W = 11;
  localparam int DEAD_W = 10;
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEAD_TIME_US = 100;
  localparam int DEAD_CYCLES = (DEAD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_LEVEL = 8'h08;
  localparam logic [7:0] OFS_LENGTH = 8'h0C;
  localparam logic [7:0] OFS_BEGIN = 8'h10;
  localparam logic [7:0] OFS_POINTS = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_PROGRESS = 8'h1C;
  localparam logic [7:0] OFS_PT_PROGRESS = 8'h20;
  localparam logic [7:0] OFS_FULL_LENGTH = 8'h24;
  localparam logic [7:0] OFS_READ_ADDR = 8'h28;
  localparam logic [7:0] OFS_READ_XY = 8'h2C;
  localparam logic [7:0] OFS_READ_Z = 8'h30;

  // ****************************************
  // Command bit positions
  // ****************************************
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_ARM_BIT = 1;
  localparam int CMD_FORCE_BIT = 2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARMING = 3'b001,
    ST_ARMED = 3'b010,
    ST_TRIGGERED = 3'b011,
    ST_DONE = 3'b100
  } trig_state_type;

  typedef enum logic [1:0] {
    MODE_AUTO = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_SINGLE = 2'b10
  } mode_type;

  typedef enum logic [2:0] {
    SRC_COAX = 3'b000,
    SRC_SOCKET = 3'b001,
    SRC_X = 3'b010,
    SRC_Y = 3'b011,
    SRC_Z = 3'b100
  } src_type;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] z;
    logic signed [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] x;
  } sample_type;

  typedef struct packed {
    logic jack_output_sync_select;
    logic jack_output_invert;
    logic jack_output_enable;
    logic coax_sync;
    logic coax_invert;
    logic coax_enable;
    mode_type mode;
    logic falling;
    src_type source;
  } cfg_type;

  localparam int CFG_W = $bits(cfg_type);

  typedef struct packed {
    trig_state_type state;
    cfg_type cfg;
    logic signed [SAMPLE_W-1:0] level;
    logic [CNT_W-1:0] len;
    logic signed [15:0] start_ofs;
    logic [CNT_W-1:0] points;
    logic [AW-1:0] rd_addr;
    logic [AW-1:0] ring_wr;
    logic [CNT_W-1:0] fill;
    logic [15:0] skip;
    logic [CNT_W-1:0] pt_len;
    logic [CNT_W-1:0] progress;
    logic [CNT_W-1:0] point_progress_count;
    logic [2*CNT_W-1:0] full_waveform_length;
    logic [DEAD_W-1:0] dead;
    logic dval;
    sample_type sample_q;
    logic coax_out;
    logic jack_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctl_type;

  typedef struct packed {
    logic prev;
    logic hit;
  } edge_type;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CNT_W-1:0] LENGTH_RESET = 11'h064;
  localparam logic [CNT_W-1:0] POINTS_RESET = 11'h001;
  localparam logic signed [SAMPLE_W-1:0] LEVEL_RESET = 16'sh0000;
  localparam logic signed [15:0] BEGIN_RESET = 16'sh0000;
  localparam cfg_type CFG_RESET = '{source: SRC_COAX, mode: MODE_NORMAL, default: 1'b0};
  localparam edge_type EDGE_RESET = '{default: 1'b0};
  localparam ctl_type CTL_RESET = '{state: ST_IDLE, cfg: CFG_RESET, level: LEVEL_RESET,
    len: LENGTH_RESET, start_ofs: BEGIN_RESET, points: POINTS_RESET, default: '0};

  function automatic logic is_field_src(input src_type s);
    return (s == SRC_X) || (s == SRC_Y) || (s == SRC_Z);
  endfunction

endpackage

// ===== core/wave_mem.sv
`timescale 1ns/1ps
module wave_mem import trig_pkg::*; (
  input logic clk, // Core clock
  input logic rstn, // Synchronous reset, low
  input logic ce, // Clock enable
  input logic we, // Write strobe
  input logic [AW-1:0] waddr, // Write address
  input sample_type wdata, // Write data
  input logic [AW-1:0] raddr, // Read address
  output sample_type rdata // Registered read data
);

  sample_type mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ===== core/trig_edge.sv
`timescale 1ns/1ps
module trig_edge import trig_pkg::*; (
  input logic clk, // Core clock
  input logic rstn, // Synchronous reset, low
  input logic ce, // Clock enable
  input cfg_type cfg, // Source and polarity
  input logic signed [SAMPLE_W-1:0] level, // Field threshold
  input logic coax_in, // Coaxial trigger input
  input logic socket_in, // Socket trigger input
  input logic sample_valid, // Field sample strobe
  input sample_type sample, // Field sample
  output logic hit // Edge found, one cycle
);

  edge_type st;
  edge_type next_st;
  logic cur;
  logic upd;

  always_comb begin
    next_st = st;
    case (cfg.source)
      SRC_COAX: cur = coax_in; // R1
      SRC_SOCKET: cur = socket_in; // R1
      SRC_X: cur = sample.x >= level; // R16
      SRC_Y: cur = sample.y >= level; // R16
      SRC_Z: cur = sample.z >= level; // R16
      default: cur = 1'b0;
    endcase
    upd = is_field_src(cfg.source) ? sample_valid : 1'b1;
    next_st.hit = upd && (cfg.falling ? (st.prev && !cur) : (!st.prev && cur)); // R1
    if (upd) begin
      next_st.prev = cur;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= EDGE_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign hit = st.hit;

  a_edge_rise: assert property (@(posedge clk) disable iff (!rstn) // R16
    ce && upd && !cfg.falling && !st.prev && cur |=> hit)
    else $error("rising edge missed");

  a_edge_quiet: assert property (@(posedge clk) disable iff (!rstn) // R1
    ce && !upd |=> !hit)
    else $error("hit without a sample");

endmodule

// ===== core/trig_capture.sv
// Overview of operation
// R1 - Trigger source: coax, socket, or x/y/z field crossing; rising or falling edge.
// R2 - After each accepted event, ignore events for 100 us dead time.
// R3 - Modes: automatic free-running, normal per event, single one-shot.
// R4 - Each point stores exactly the configured trigger length of samples.
// R5 - First stored sample sits at signed begin offset from the trigger sample.
// R6 - Force request triggers immediately without a real event.
// R7 - Each output pulses on every event, forced too, or in sync mode.
// R8 - Coax and socket outputs each have enable, invert and sync select.
// R9 - Point count above one builds one waveform from equal sub-waveforms.
// R10 - Done only after all points captured; points recorded count is readable.
// R11 - Host changes configuration only while idle.
// R12 - Host reads captured samples only while done; the code returns them in any state.
// R13 - Arm passes through arming state, then armed.
// R14 - Events processed only while armed; host checks armed first.
// R15 - Readable sample progress counter for the current acquisition.
// R16 - Field sources compare the axis value against a programmable level.
// R17 - Full waveform length reported as length times points.
// R18 - Clear, arm and force requests change state; state is readable.
// R19 - Clear returns to idle from anywhere and resets progress counters.
// R20 - Auto re-arms after done, normal after readout, single holds done.
`timescale 1ns/1ps
module trig_capture import trig_pkg::*; (
  input logic CORE_CLK, // Core clock, 10 MHz
  input logic RSTN, // Synchronous reset, low
  input logic CE, // Clock enable
  input logic PSEL, // APB select
  input logic PENABLE, // APB enable
  input logic PWRITE, // APB direction
  input logic [7:0] PADDR, // APB byte address
  input logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error
  input logic SAMPLE_VALID, // Field sample strobe
  input sample_type SAMPLE, // Field sample
  input logic COAX_TRIG_IN, // Coaxial trigger input
  input logic AUX_TRIGGER_SOCKET_IN, // Socket trigger input
  output logic COAX_TRIG_OUT, // Coaxial trigger output
  output logic JACK_TRIG_OUT // Socket trigger output
);

  ctl_type st;
  ctl_type n;
  logic wr;
  logic rd;
  logic cmd_clear;
  logic cmd_arm;
  logic cmd_force;
  logic evt;
  logic sync_pulse;
  logic rearm;
  logic store;
  logic readout_done;
  logic edge_hit;
  logic [15:0] pre;
  logic [15:0] post;
  sample_type ring_rdata;
  sample_type wave_rdata;
  sample_type delayed;

  function automatic logic out_level(input logic en, input logic inv, input logic sel,
                                     input logic sync, input logic ev);
    return en & ((sel ? sync : ev) ^ inv);
  endfunction

  // ****************************************
  // Trigger detection and memories
  // ****************************************
  trig_edge u_edge (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .ce(CE),
    .cfg(st.cfg),
    .level(st.level),
    .coax_in(COAX_TRIG_IN),
    .socket_in(AUX_TRIGGER_SOCKET_IN),
    .sample_valid(SAMPLE_VALID),
    .sample(SAMPLE),
    .hit(edge_hit)
  );

  // Pre-trigger history line
  wave_mem u_ring (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .ce(CE),
    .we(SAMPLE_VALID),
    .waddr(st.ring_wr),
    .wdata(SAMPLE),
    .raddr(st.ring_wr - pre[AW-1:0]),
    .rdata(ring_rdata)
  );

  wave_mem u_wave (
    .clk(CORE_CLK),
    .rstn(RSTN),
    .ce(CE),
    .we(store),
    .waddr(st.progress[AW-1:0]),
    .wdata(delayed),
    .raddr(n.rd_addr),
    .rdata(wave_rdata)
  );

  assign pre = st.start_ofs[15] ? 16'(-st.start_ofs) : 16'h0000;
  assign post = st.start_ofs[15] ? 16'h0000 : 16'(st.start_ofs);
  assign delayed = (pre == 16'h0000) ? st.sample_q : ring_rdata; // R5

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = st;
    wr = PSEL && PENABLE && PWRITE && st.pready;
    rd = PSEL && PENABLE && !PWRITE && st.pready;
    cmd_clear = wr && (PADDR == OFS_CMD) && PWDATA[CMD_CLEAR_BIT]; // R18
    cmd_arm = wr && (PADDR == OFS_CMD) && PWDATA[CMD_ARM_BIT]; // R18
    cmd_force = wr && (PADDR == OFS_CMD) && PWDATA[CMD_FORCE_BIT]; // R18
    readout_done = rd && (PADDR == OFS_READ_Z) && (st.state == ST_DONE)
      && ({12'h000, st.rd_addr} == st.full_waveform_length - 22'h000001);
    evt = 1'b0;
    sync_pulse = 1'b0;
    rearm = 1'b0;
    store = 1'b0;
    n.pready = PSEL && !PENABLE;
    n.pslverr = 1'b0;
    n.full_waveform_length = st.len * st.points; // R17
    if (PSEL && !PENABLE) begin
      case (PADDR)
        OFS_CMD: n.prdata = 32'h00000000;
        OFS_CONFIG: n.prdata = 32'(st.cfg);
        OFS_LEVEL: n.prdata = 32'(st.level);
        OFS_LENGTH: n.prdata = 32'(st.len);
        OFS_BEGIN: n.prdata = 32'(st.start_ofs);
        OFS_POINTS: n.prdata = 32'(st.points);
        OFS_STATE: n.prdata = 32'(st.state); // R18
        OFS_PROGRESS: n.prdata = 32'(st.progress); // R15
        OFS_PT_PROGRESS: n.prdata = 32'(st.point_progress_count); // R10
        OFS_FULL_LENGTH: n.prdata = 32'(st.full_waveform_length); // R17
        OFS_READ_ADDR: n.prdata = 32'(st.rd_addr);
        OFS_READ_XY: n.prdata = {wave_rdata.y, wave_rdata.x}; // R12
        OFS_READ_Z: n.prdata = 32'(wave_rdata.z); // R12
        default: begin
          n.prdata = 32'h00000000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    // Configuration is frozen outside idle
    if (wr && (st.state == ST_IDLE)) begin // R11
      case (PADDR)
        OFS_CONFIG: n.cfg = cfg_type'(PWDATA[CFG_W-1:0]); // R1 R3 R8
        OFS_LEVEL: n.level = PWDATA[SAMPLE_W-1:0]; // R16
        OFS_LENGTH: n.len = PWDATA[CNT_W-1:0]; // R4
        OFS_BEGIN: n.start_ofs = PWDATA[15:0]; // R5
        OFS_POINTS: n.points = PWDATA[CNT_W-1:0]; // R9
        default: ;
      endcase
    end
    if (wr && (PADDR == OFS_READ_ADDR)) begin
      n.rd_addr = PWDATA[AW-1:0];
    end
    if (rd && (PADDR == OFS_READ_Z)) begin
      n.rd_addr = st.rd_addr + 10'h001;
    end
    n.dval = SAMPLE_VALID;
    if (SAMPLE_VALID) begin
      n.sample_q = SAMPLE;
      n.ring_wr = st.ring_wr + 10'h001;
    end
    if (st.dead != '0) begin
      n.dead = st.dead - 10'h001; // R2
    end
    unique case (st.state)
      ST_IDLE: ;
      ST_ARMING: begin
        if (st.dval && (st.fill != 11'h7FF)) begin
          n.fill = st.fill + 11'h001;
        end
        // History must cover the pre-trigger span
        if ({5'h00, st.fill} >= pre) begin // R13 R5
          n.state = ST_ARMED;
          sync_pulse = 1'b1;
        end
      end
      ST_ARMED: begin // R14
        if (cmd_force || ((st.dead == '0) // R6 R2
            && (edge_hit || (st.cfg.mode == MODE_AUTO)))) begin // R3
          evt = 1'b1;
          n.state = ST_TRIGGERED;
          n.skip = post; // R5
          n.dead = DEAD_W'(DEAD_CYCLES); // R2
        end
      end
      ST_TRIGGERED: ;
      ST_DONE: begin
        rearm = (st.cfg.mode == MODE_AUTO) // R20
          || ((st.cfg.mode == MODE_NORMAL) && readout_done);
      end
    endcase
    if ((n.state == ST_TRIGGERED) && st.dval) begin
      if (n.skip != 16'h0000) begin
        n.skip = n.skip - 16'h0001; // R5
      end else begin
        store = 1'b1;
        n.progress = st.progress + 11'h001; // R15
        if (st.pt_len == st.len - 11'h001) begin // R4
          n.pt_len = '0;
          n.point_progress_count = st.point_progress_count + 11'h001; // R9
          n.state = (n.point_progress_count == st.points) ? ST_DONE : ST_ARMED; // R10
        end else begin
          n.pt_len = st.pt_len + 11'h001;
        end
      end
    end
    if (rearm || cmd_arm) begin // R13
      n.state = ST_ARMING;
      n.fill = '0;
      n.progress = '0;
      n.point_progress_count = '0;
      n.pt_len = '0;
      n.skip = '0;
    end
    if (cmd_clear) begin // R19
      n.state = ST_IDLE;
      n.progress = '0;
      n.point_progress_count = '0;
      n.pt_len = '0;
      n.skip = '0;
      n.fill = '0;
    end
    n.coax_out = out_level(st.cfg.coax_enable, st.cfg.coax_invert, // R7 R8
      st.cfg.coax_sync, sync_pulse, evt);
    n.jack_out = out_level(st.cfg.jack_output_enable, st.cfg.jack_output_invert, // R7 R8
      st.cfg.jack_output_sync_select, sync_pulse, evt);
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      st <= CTL_RESET;
    end else if (CE) begin
      st <= n;
    end
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign COAX_TRIG_OUT = st.coax_out;
  assign JACK_TRIG_OUT = st.jack_out;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);

  sequence s_arm_req;
    CE && cmd_arm && !cmd_clear;
  endsequence

  sequence s_arming_fresh;
    (st.state == ST_ARMING) && (st.progress == '0) && (st.point_progress_count == '0);
  endsequence

  a_arm_to_arming: assert property (s_arm_req |=> s_arming_fresh) // R13
    else $error("arm did not enter arming");

  a_fire_from_armed: assert property ($rose(st.state == ST_TRIGGERED) // R14
    |-> $past(st.state) == ST_ARMED)
    else $error("triggered entered from wrong state");

  a_dead_reload: assert property (CE && evt |=> st.dead == DEAD_W'(DEAD_CYCLES)) // R2
    else $error("dead time not reloaded");

  a_dead_blocks: assert property (CE && (st.state == ST_ARMED) && (st.dead != '0) // R2
    && !cmd_force && !cmd_arm && !cmd_clear |=> st.state == ST_ARMED)
    else $error("event taken inside dead time");

  a_force_fires: assert property (CE && cmd_force && (st.state == ST_ARMED) // R6
    && !cmd_arm && !cmd_clear |=> st.state == ST_TRIGGERED)
    else $error("force ignored while armed");

  a_clear_idle: assert property (CE && cmd_clear |=> (st.state == ST_IDLE) // R19
    && (st.progress == '0) && (st.point_progress_count == '0))
    else $error("clear did not reach idle");

  a_done_points: assert property ($rose(st.state == ST_DONE) // R10
    |-> st.point_progress_count == st.points)
    else $error("done before all points");

  a_done_length: assert property ($rose(st.state == ST_DONE) // R4
    |-> 22'(st.progress) == st.full_waveform_length)
    else $error("sample count differs from full length");

  a_single_holds: assert property (CE && (st.state == ST_DONE) // R20
    && (st.cfg.mode == MODE_SINGLE) && !cmd_arm && !cmd_clear |=> st.state == ST_DONE)
    else $error("single mode left done");

  a_auto_rearm: assert property (CE && (st.state == ST_DONE) // R3
    && (st.cfg.mode == MODE_AUTO) && !cmd_clear |=> st.state == ST_ARMING)
    else $error("auto mode did not re-arm");

  a_coax_pulse: assert property (CE && evt && st.cfg.coax_enable && !st.cfg.coax_sync // R7
    |=> COAX_TRIG_OUT != st.cfg.coax_invert)
    else $error("coax output missed event");

  a_jack_off: assert property (CE && !st.cfg.jack_output_enable |=> !JACK_TRIG_OUT) // R8
    else $error("disabled socket output drove");

endmodule

// ===== test/trig_source_model.sv
`timescale 1ns/1ps
module trig_source_model import trig_pkg::*; (
  input wire logic clk, // Core clock
  input wire logic rstn, // Synchronous reset, low
  input wire logic run, // Produce field samples
  input wire logic [1:0] fire, // Pulse: bit 0 coax, bit 1 socket
  output sample_type sample_out, // Field sample, sawtooth on all axes
  output logic sample_valid, // One cycle in eight while running
  output logic coax_line, // Coax trigger level
  output logic socket_line // Socket trigger level
);
  logic [5:0] cnt;
  logic [2:0] div;
  logic [2:0] hold_c;
  logic [2:0] hold_s;

  // Bus carries a changing pattern outside the strobe
  assign sample_out = sample_valid ? {3{10'h000, cnt}} : ~{3{10'h000, cnt}};

  always @(posedge clk) begin
    if (!rstn) begin
      div <= 3'h0;
      cnt <= 6'h00;
      sample_valid <= 1'b0;
      hold_c <= 3'h0;
      hold_s <= 3'h0;
      coax_line <= 1'b0;
      socket_line <= 1'b0;
    end else begin
      div <= div + 3'h1;
      sample_valid <= run && (div == 3'h7);
      if (run && (div == 3'h7)) begin
        cnt <= cnt + 6'h01;
      end
      hold_c <= fire[0] ? 3'h4 : ((hold_c != 3'h0) ? hold_c - 3'h1 : 3'h0);
      hold_s <= fire[1] ? 3'h4 : ((hold_s != 3'h0) ? hold_s - 3'h1 : 3'h0);
      coax_line <= fire[0] || (hold_c > 3'h1);
      socket_line <= fire[1] || (hold_s > 3'h1);
    end
  end
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench import trig_pkg::*; ();
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, svalid, coax, sock, cout, jout, ev;
  logic run = 1'b0;
  logic ce = 1'b1;
  logic [1:0] fire = 2'b00;
  sample_type samp;
  logic [31:0] rv;
  logic [15:0] xs [8];
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int ncoax = 0;
  int njack = 0;

  always #50 clk = ~clk;

  trig_capture trig_capture_inst (.CORE_CLK(clk), .RSTN(rstn), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SAMPLE_VALID(svalid), .SAMPLE(samp),
    .COAX_TRIG_IN(coax), .AUX_TRIGGER_SOCKET_IN(sock), .COAX_TRIG_OUT(cout),
    .JACK_TRIG_OUT(jout));

  trig_source_model trig_source_model_inst (.clk(clk), .rstn(rstn), .run(run), .fire(fire),
    .sample_out(samp), .sample_valid(svalid), .coax_line(coax), .socket_line(sock));

  // ****
  // Pulse counters and watchdog
  // ****
  always @(posedge clk) begin
    cyc++;
    if (cout === 1'b1) ncoax++;
    if (jout === 1'b0) njack++;
    if (cyc == 40000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // ****
  // Bus access
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for pready; only the watchdog ends a wait that never sees it
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    cmp(n, e, rv);
  endtask

  task automatic wait_reg(input string n, input logic [7:0] a, input logic [31:0] e);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h00000000);
      k++;
    end while (rv !== e && k < 1500);
    cmp(n, e, rv);
  endtask

  task automatic setup(input logic [31:0] c, input logic [31:0] l, input logic [31:0] b,
      input logic [31:0] p);
    wr(OFS_CMD, 32'h00000001);
    wr(OFS_CONFIG, c);
    wr(OFS_LENGTH, l);
    wr(OFS_BEGIN, b);
    wr(OFS_POINTS, p);
  endtask

  task automatic fire_pin(input logic [1:0] m);
    fire <= m;
    @(posedge clk);
    fire <= 2'b00;
    @(posedge clk);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rc("length", OFS_LENGTH, 32'h00000064);
    rc("points", OFS_POINTS, 32'h00000001);
    rc("config", OFS_CONFIG, 32'h00000010);
    rc("state", OFS_STATE, 32'h00000000);
    rc("unmapped", 8'h3C, 32'h00000000);
    cmp("slverr", 32'h00000001, {31'h0, ev});
    wr(OFS_LEVEL, 32'h00000020);
    rc("level", OFS_LEVEL, 32'h00000020);
    run <= 1'b1;
    // ****
    // Every source, single shot
    // ****
    for (int s = 0; s < 5; s++) begin
      setup(32'h00000060 + s + ((s == 1) ? 32'h8 : 32'h0), 32'h4, 32'h0, 32'h1);
      wr(OFS_CMD, 32'h00000002);
      wait_reg("armed", OFS_STATE, 32'h00000002);
      if (s < 2) begin
        repeat (1000) @(posedge clk);
        fire_pin(2'(s + 1));
      end
      wait_reg("src_done", OFS_STATE, 32'h00000004);
    end
    // ****
    // Two points, dead time, outputs
    // ****
    setup(32'h00000E60, 32'h4, 32'hFFFFFFFE, 32'h2);
    rc("full", OFS_FULL_LENGTH, 32'h00000008);
    run <= 1'b0;
    ncoax = 0;
    njack = 0;
    wr(OFS_CMD, 32'h00000002);
    rc("arming", OFS_STATE, 32'h00000001);
    // Samples arriving while frozen must not count
    ce <= 1'b0;
    run <= 1'b1;
    repeat (200) @(posedge clk);
    run <= 1'b0;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    rc("frozen", OFS_STATE, 32'h00000001);
    run <= 1'b1;
    wait_reg("armed", OFS_STATE, 32'h00000002);
    wr(OFS_LENGTH, 32'h00000007);
    rc("locked", OFS_LENGTH, 32'h00000004);
    repeat (1000) @(posedge clk);
    fire_pin(2'b01);
    wait_reg("pt1", OFS_PT_PROGRESS, 32'h00000001);
    fire_pin(2'b01);
    repeat (100) @(posedge clk);
    rc("dead", OFS_PT_PROGRESS, 32'h00000001);
    repeat (1000) @(posedge clk);
    fire_pin(2'b01);
    wait_reg("done", OFS_STATE, 32'h00000004);
    rc("pt2", OFS_PT_PROGRESS, 32'h00000002);
    rc("progress", OFS_PROGRESS, 32'h00000008);
    repeat (50) @(posedge clk);
    rc("hold", OFS_STATE, 32'h00000004);
    cmp("coax_pulses", 32'h2, ncoax);
    cmp("jack_pulses", 32'h1, njack);
    cmp("jack_idle", 32'h1, {31'h0, jout});
    wr(OFS_READ_ADDR, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, OFS_READ_XY, 32'h00000000);
      xs[i] = rv[15:0];
      cmp("y", {16'h0000, xs[i]}, {16'h0000, rv[31:16]});
      rc("z", OFS_READ_Z, {16'h0000, xs[i]});
    end
    for (int i = 1; i < 8; i++) begin
      if (i != 4) cmp("step", {26'h0, 6'(xs[i-1][5:0] + 6'h01)}, {16'h0, xs[i]});
    end
    // ****
    // Force, clear, re-arm
    // ****
    setup(32'h00000050, 32'h4, 32'h3, 32'h2);
    wr(OFS_CMD, 32'h00000002);
    wait_reg("armed", OFS_STATE, 32'h00000002);
    ncoax = 0;
    wr(OFS_CMD, 32'h00000004);
    wait_reg("force_pt", OFS_PT_PROGRESS, 32'h00000001);
    rc("progress", OFS_PROGRESS, 32'h00000004);
    cmp("force_pulse", 32'h1, ncoax);
    wr(OFS_CMD, 32'h00000001);
    rc("clr_state", OFS_STATE, 32'h00000000);
    rc("clr_prog", OFS_PROGRESS, 32'h00000000);
    rc("clr_pt", OFS_PT_PROGRESS, 32'h00000000);
    wr(OFS_POINTS, 32'h00000001);
    wr(OFS_CMD, 32'h00000002);
    wait_reg("armed", OFS_STATE, 32'h00000002);
    wr(OFS_CMD, 32'h00000004);
    wait_reg("done", OFS_STATE, 32'h00000004);
    wr(OFS_READ_ADDR, 32'h00000003);
    apb(1'b0, OFS_READ_Z, 32'h00000000);
    wait_reg("rearm", OFS_STATE, 32'h00000002);
    setup(32'h00000040, 32'h4, 32'h0, 32'h1);
    wr(OFS_CMD, 32'h00000002);
    wait_reg("armed", OFS_STATE, 32'h00000002);
    ncoax = 0;
    wr(OFS_CMD, 32'h00000004);
    wait_reg("auto", OFS_STATE, 32'h00000002);
    wr(OFS_CMD, 32'h00000004);
    repeat (20) @(posedge clk);
    cmp("auto_pulses", 32'h2, ncoax);
    close_out();
  end
endmodule
